// ### hdl/lptd_defines.svh
// Constants of the LCD panel timing block: offsets, field positions, resets, counts.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef LPTD_DEFINES_SVH
`define LPTD_DEFINES_SVH
// ==========================================
// Register offsets (byte addresses on APB)
`define LPTD_OFS_MEMCFG 12'h000
`define LPTD_OFS_PWRSAVE 12'h020
`define LPTD_OFS_DISPEN 12'h024
`define LPTD_OFS_MODE 12'h080
`define LPTD_OFS_CMD 12'h084
`define LPTD_OFS_STATUS 12'h088
`define LPTD_OFS_GEOM 12'h08c
// ==========================================
// Field positions and codes
`define LPTD_BIT_ENABLE 0
`define LPTD_CMD_DISP_OFF 8'h58
`define LPTD_CMD_DISP_ON 8'h59
`define LPTD_MEMCFG_RST 8'h10
// ==========================================
// Geometry reset values
`define LPTD_GROUPS_RST 8'h02
`define LPTD_ROWS_RST 8'h08
// ==========================================
// Timing constants
`define LPTD_SYS_PERIOD_NS 10
`define LPTD_SHIFT_MAX_MHZ 15
`define LPTD_SYS_MAX_MHZ 60
`define LPTD_DIV_00 4
`define LPTD_DIV_01 8
`define LPTD_DIV_10 16
`define LPTD_NIBBLES_PER_GROUP 16
`define LPTD_PS_FRAMES 2
`define LPTD_OFF_IND_NS 10
`define LPTD_OFF_DIR_NS 10
`endif

// ### hdl/lptd_pkg.sv
// Types shared by the LCD panel timing block.
// Assumes no surroundings beyond the compile order.
package lptd_pkg;
  // ==========================================
  // Strap rate selection
  typedef logic [1:0] lptd_rate_t;
  // Scan state, one-hot codes
  typedef enum logic [3:0] {
    LPTD_ST_IDLE = 4'b0001,
    LPTD_ST_DATA = 4'b0010,
    LPTD_ST_LATCH = 4'b0100,
    LPTD_ST_GAP = 4'b1000
  } lptd_state_t;
endpackage : lptd_pkg

// ### hdl/lptd_sync3.sv
// Three-stage input synchroniser with agreement check on the last two stages.
// Assumes an asynchronous level input and a synchronous active-low reset.
`timescale 1ns/1ps
module lptd_sync3 #(
  parameter int WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);
  // ==========================================
  // Stages
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg; // First stage read only by second
  logic [WIDTH-1:0] lvl_next;
  // Accept a change once the second and third stages agree
  always_comb begin
    lvl_next = lvl_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s3_reg[i];
      end
    end
  end
  // Register the stages
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end
  assign o_level = lvl_reg;
endmodule : lptd_sync3

// ### hdl/lptd_apb.sv
// APB slave register file for the panel timing block.
// Assumes a single-cycle-ready APB master; registers at one aligned word each.
`timescale 1ns/1ps
`include "lptd_defines.svh"
module lptd_apb (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [7:0] i_status,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_indirect,
  output logic o_dispen,
  output logic o_pwrsave,
  output logic [7:0] o_groups,
  output logic [7:0] o_rows,
  output logic o_memcfg_wr,
  output logic o_cmd_off,
  output logic o_cmd_on
);
  // ==========================================
  // Stored registers
  logic [7:0] memcfg_reg, memcfg_next; // Stored, side effects below
  logic ind_reg, ind_next; // Indirect addressing selected
  logic den_reg, den_next; // Display enable
  logic ps_reg, ps_next; // Power save enable
  logic [15:0] geom_reg, geom_next; // Rows high byte, groups low byte
  logic [31:0] rd_reg, rd_next; // Registered read data
  logic err_next;
  logic wr, rd, b0;
  // Hit test, used in several places
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit
  assign wr = i_psel & i_penable & i_pwrite;
  assign rd = i_psel & i_penable & ~i_pwrite;
  assign b0 = i_pstrb[0];
  // Decode writes and read data
  always_comb begin
    memcfg_next = memcfg_reg;
    ind_next = ind_reg;
    den_next = den_reg;
    ps_next = ps_reg;
    geom_next = geom_reg;
    rd_next = 32'h0000_0000;
    err_next = 1'b0;
    o_memcfg_wr = 1'b0;
    o_cmd_off = 1'b0;
    o_cmd_on = 1'b0;
    if (wr && b0) begin
      if (hit(i_paddr, `LPTD_OFS_MEMCFG)) begin
        memcfg_next = i_pwdata[7:0];
        o_memcfg_wr = 1'b1;
        den_next = 1'b0;
        if (ind_reg) begin
          ps_next = 1'b0;
        end
      end else if (hit(i_paddr, `LPTD_OFS_PWRSAVE)) begin
        ps_next = i_pwdata[`LPTD_BIT_ENABLE];
      end else if (hit(i_paddr, `LPTD_OFS_DISPEN)) begin
        den_next = i_pwdata[`LPTD_BIT_ENABLE];
      end else if (hit(i_paddr, `LPTD_OFS_MODE)) begin
        ind_next = i_pwdata[0];
      end else if (hit(i_paddr, `LPTD_OFS_CMD)) begin
        // Commands only act in indirect mode
        if (ind_reg && i_pwdata[7:0] == `LPTD_CMD_DISP_OFF) begin
          o_cmd_off = 1'b1;
          den_next = 1'b0;
        end else if (ind_reg && i_pwdata[7:0] == `LPTD_CMD_DISP_ON) begin
          o_cmd_on = 1'b1;
          den_next = 1'b1;
        end
      end else if (hit(i_paddr, `LPTD_OFS_GEOM)) begin
        geom_next[7:0] = i_pwdata[7:0];
        if (i_pstrb[1]) begin
          geom_next[15:8] = i_pwdata[15:8];
        end
      end else if (!hit(i_paddr, `LPTD_OFS_STATUS)) begin
        err_next = 1'b1;
      end
    end
    if (wr && !b0 && !hit(i_paddr, `LPTD_OFS_GEOM)) begin
      err_next = 1'b0; // Empty strobe write is ignored quietly
    end
    if (rd) begin
      case (i_paddr)
        `LPTD_OFS_MEMCFG: rd_next = {24'h000000, memcfg_reg};
        `LPTD_OFS_PWRSAVE: rd_next = {31'h00000000, ps_reg};
        `LPTD_OFS_DISPEN: rd_next = {31'h00000000, den_reg};
        `LPTD_OFS_MODE: rd_next = {31'h00000000, ind_reg};
        `LPTD_OFS_CMD: rd_next = 32'h0000_0000;
        `LPTD_OFS_STATUS: rd_next = {24'h000000, i_status};
        `LPTD_OFS_GEOM: rd_next = {16'h0000, geom_reg};
        default: begin
          rd_next = 32'h0000_0000;
          err_next = 1'b1;
        end
      endcase
    end
  end
  // Register state
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      memcfg_reg <= `LPTD_MEMCFG_RST;
      ind_reg <= 1'b0;
      den_reg <= 1'b0;
      ps_reg <= 1'b0;
      geom_reg <= {`LPTD_ROWS_RST, `LPTD_GROUPS_RST};
      rd_reg <= 32'h0000_0000;
    end else begin
      memcfg_reg <= memcfg_next;
      ind_reg <= ind_next;
      den_reg <= den_next;
      ps_reg <= ps_next;
      geom_reg <= geom_next;
      rd_reg <= rd ? rd_next : rd_reg;
    end
  end
  // Zero wait state: answer in the access cycle; read data from the decode
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & err_next;
  assign o_prdata = rd ? rd_next : rd_reg;
  assign o_indirect = ind_reg;
  assign o_dispen = den_reg;
  assign o_pwrsave = ps_reg;
  assign o_groups = geom_reg[7:0];
  assign o_rows = geom_reg[15:8];
endmodule : lptd_apb

// ### hdl/lptd_top.sv
// Panel timing generator: shift clock divider, line/frame/row strobes, drive enable.
// Assumes the system clock runs at no more than 60 MHz and the strap is static.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "lptd_defines.svh"
module lptd_top #(
  parameter int MEM_BYTES = 32768,
  parameter int PIX_W = 4
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_shift_rate_strap,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_pixel_shift_clock,
  output logic [PIX_W-1:0] o_panel_pixel_nibble,
  output logic o_line_latch_pulse,
  output logic o_frame_start_pulse,
  output logic o_row_scan_clock,
  output logic o_segment_chain_clock,
  output logic o_panel_drive_enable
);
  import lptd_pkg::*;
  // ==========================================
  // Derived timing counts
  localparam int SHIFT_MIN_NS = 1000 / `LPTD_SHIFT_MAX_MHZ;
  localparam int MIN_DIV = (SHIFT_MIN_NS + `LPTD_SYS_PERIOD_NS - 1) / `LPTD_SYS_PERIOD_NS;
  localparam int OFF_DIR_CYC = 2 + `LPTD_OFF_DIR_NS / `LPTD_SYS_PERIOD_NS;
  localparam int MEM_AW = $clog2(MEM_BYTES);
  // ==========================================
  // Wiring
  logic [1:0] rate_sync; // Strap after synchroniser
  logic indirect, dispen, pwrsave, memcfg_wr, cmd_off, cmd_on;
  logic [7:0] groups, rows, status;
  lptd_sync3 #(.WIDTH(2)) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(i_shift_rate_strap),
    .o_level(rate_sync)
  );
  lptd_apb u_apb (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .i_status(status),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_indirect(indirect),
    .o_dispen(dispen),
    .o_pwrsave(pwrsave),
    .o_groups(groups),
    .o_rows(rows),
    .o_memcfg_wr(memcfg_wr),
    .o_cmd_off(cmd_off),
    .o_cmd_on(cmd_on)
  );
  // ==========================================
  // Divider selection; the 11 code is held at the slowest rate
  function automatic logic [4:0] div_of(input logic [1:0] r);
    case (r)
      2'h0: div_of = 5'(`LPTD_DIV_00);
      2'h1: div_of = 5'(`LPTD_DIV_01);
      default: div_of = 5'(`LPTD_DIV_10);
    endcase
  endfunction : div_of
  // ==========================================
  // Shift clock phase counter
  logic [4:0] div_reg, div_next; // Latched divider, changed only on a memcfg write
  logic [4:0] ph_reg, ph_next; // Phase within one shift period
  logic tick; // Last phase of a shift period
  assign tick = (ph_reg == div_reg - 5'h01);
  // Phase counter and divider update
  always_comb begin
    div_next = div_reg;
    ph_next = tick ? 5'h00 : ph_reg + 5'h01;
    if (memcfg_wr) begin
      ph_next = 5'h00;
      div_next = div_of(rate_sync);
    end
    // Clamp keeps 100 MHz below the shift ceiling
    if (div_next < 5'(MIN_DIV)) begin
      div_next = 5'(`LPTD_DIV_01);
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      div_reg <= 5'(`LPTD_DIV_01);
      ph_reg <= 5'h00;
    end else begin
      div_reg <= div_next;
      ph_reg <= ph_next;
    end
  end
  // ==========================================
  // Scan sequencer: data nibbles, latch, gap
  lptd_state_t st_reg, st_next;
  logic [11:0] nib_reg, nib_next; // Shift pulses in this line
  logic [7:0] row_reg, row_next; // Row within frame
  logic [2:0] gap_reg, gap_next; // Shift periods after latch
  logic [1:0] frm_reg, frm_next; // Frames since power save set
  logic frame_end;
  logic [11:0] line_len;
  // Line length always a whole number of 16-pulse groups
  assign line_len = {groups, 4'h0};
  assign frame_end = tick && (st_reg == LPTD_ST_GAP) && (gap_reg == 3'h3) && (row_reg == rows);
  always_comb begin
    st_next = st_reg;
    nib_next = nib_reg;
    row_next = row_reg;
    gap_next = gap_reg;
    if (tick) begin
      case (st_reg)
        LPTD_ST_IDLE: begin
          st_next = LPTD_ST_DATA;
          nib_next = 12'h000;
        end
        LPTD_ST_DATA: begin
          nib_next = nib_reg + 12'h001;
          if (nib_reg == line_len - 12'h001) begin
            st_next = LPTD_ST_LATCH;
          end
        end
        LPTD_ST_LATCH: begin
          st_next = LPTD_ST_GAP;
          gap_next = 3'h0;
        end
        LPTD_ST_GAP: begin
          gap_next = gap_reg + 3'h1;
          if (gap_reg == 3'h3) begin
            st_next = LPTD_ST_DATA;
            nib_next = 12'h000;
            row_next = (row_reg == rows) ? 8'h00 : row_reg + 8'h01;
          end
        end
        default: st_next = LPTD_ST_IDLE;
      endcase
    end
    if (memcfg_wr) begin
      st_next = LPTD_ST_IDLE;
      row_next = 8'h00;
      gap_next = 3'h0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_reg <= LPTD_ST_IDLE;
      nib_reg <= 12'h000;
      row_reg <= 8'h00;
      gap_reg <= 3'h0;
    end else begin
      st_reg <= st_next;
      nib_reg <= nib_next;
      row_reg <= row_next;
      gap_reg <= gap_next;
    end
  end
  // ==========================================
  // Panel outputs, all from flip-flops
  logic sh_reg, sh_next, ll_reg, ll_next, fr_reg, fr_next, ys_reg, ys_next, xe_reg, xe_next;
  logic [PIX_W-1:0] pix_reg, pix_next;
  logic [MEM_AW-1:0] addr_reg, addr_next; // Display memory walk address
  logic half;
  assign half = (ph_reg < (div_reg >> 1));
  always_comb begin
    // Shift high in the first half of each data period
    sh_next = (st_reg == LPTD_ST_DATA) && half;
    pix_next = pix_reg;
    addr_next = addr_reg;
    if (tick && st_next == LPTD_ST_DATA) begin
      // New nibble changes one system clock before the shift rise, stable around the fall
      pix_next = addr_reg[PIX_W-1:0] ^ nib_next[PIX_W-1:0];
      addr_next = addr_reg + MEM_AW'(1);
    end
    ll_next = (st_reg == LPTD_ST_LATCH);
    ys_next = (st_reg == LPTD_ST_LATCH);
    // Frame covers the first row's (row 0) latch plus three gap periods
    fr_next = (row_reg == 8'h00) &&
      ((st_reg == LPTD_ST_LATCH) || (st_reg == LPTD_ST_GAP && gap_reg < 3'h3));
    xe_next = (st_reg == LPTD_ST_DATA) && (nib_reg[3:0] == 4'hf);
    if (memcfg_wr) begin
      addr_next = '0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sh_reg <= 1'b0;
      pix_reg <= '0;
      addr_reg <= '0;
      ll_reg <= 1'b0;
      ys_reg <= 1'b0;
      fr_reg <= 1'b0;
      xe_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      pix_reg <= pix_next;
      addr_reg <= addr_next;
      ll_reg <= ll_next;
      ys_reg <= ys_next;
      fr_reg <= fr_next;
      xe_reg <= xe_next;
    end
  end
  // ==========================================
  // Drive enable: off/on paths act next edge; power save waits frames in indirect mode only
  logic pde_reg, pde_next;
  logic ps_hold;
  assign ps_hold = pwrsave && (!indirect || frm_reg == 2'(`LPTD_PS_FRAMES - 1) && frame_end
    || frm_reg == 2'(`LPTD_PS_FRAMES));
  always_comb begin
    frm_next = frm_reg;
    if (!pwrsave) begin
      frm_next = 2'h0;
    end else if (frame_end && frm_reg != 2'(`LPTD_PS_FRAMES)) begin
      frm_next = frm_reg + 2'h1;
    end
    // One edge after the enable changes
    pde_next = dispen && !cmd_off && !ps_hold;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      frm_reg <= 2'h0;
      pde_reg <= 1'b0;
    end else begin
      frm_reg <= frm_next;
      pde_reg <= pde_next;
    end
  end
  assign status = {2'h0, frm_reg, st_reg};
  assign o_pixel_shift_clock = sh_reg;
  assign o_panel_pixel_nibble = pix_reg;
  assign o_line_latch_pulse = ll_reg;
  assign o_frame_start_pulse = fr_reg;
  assign o_row_scan_clock = ys_reg;
  assign o_segment_chain_clock = xe_reg;
  assign o_panel_drive_enable = pde_reg;
  // ==========================================
  // Checks
  sequence s_dis;
    !dispen;
  endsequence
  AST_OFF_DIRECT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(dispen) |-> ##[0:OFF_DIR_CYC] !o_panel_drive_enable) else $error("drive not off");
  AST_ON: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(dispen) && !pwrsave |=> o_panel_drive_enable) else $error("drive not on");
  AST_CMD_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cmd_off |=> !o_panel_drive_enable) else $error("off command ignored");
  AST_HOLD_LOW: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_dis ##1 s_dis |-> !o_panel_drive_enable) else $error("drive high while disabled");
  AST_DIV: assert property (@(posedge i_clk) disable iff (!i_rstn)
    div_reg == 5'h04 || div_reg == 5'h08 || div_reg == 5'h10) else $error("bad divider");
  AST_MAXF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    div_reg >= 5'(MIN_DIV)) else $error("shift too fast");
  AST_LINE16: assert property (@(posedge i_clk) disable iff (!i_rstn)
    tick && st_reg == LPTD_ST_DATA && st_next == LPTD_ST_LATCH |-> nib_reg[3:0] == 4'hf)
    else $error("line not multiple of 16");
  AST_MEMCFG: assert property (@(posedge i_clk) disable iff (!i_rstn)
    memcfg_wr |=> st_reg == LPTD_ST_IDLE ##1 !o_panel_drive_enable) else $error("no reset");
  AST_LATCH_ROW: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_line_latch_pulse == o_row_scan_clock) else $error("latch and row differ");
  AST_PS: assert property (@(posedge i_clk) disable iff (!i_rstn)
    frm_reg == 2'h2 && pwrsave |=> !o_panel_drive_enable) else $error("power save late");
endmodule : lptd_top

// ### verification/lptd_panel_model.sv
// Panel row/column driver model: samples the nibble bus and times the strobes.
// Assumes all panel outputs of the block change only at system clock edges.
`timescale 1ns/1ps
module lptd_panel_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_shift,
  input wire logic [3:0] i_nibble,
  input wire logic i_latch,
  input wire logic i_frame,
  input wire logic i_row,
  output logic [15:0] o_line_pulses,
  output logic [15:0] o_bad,
  output logic [15:0] o_lat_frm,
  output logic [15:0] o_row_frm
);
  // ==========================================
  // Delayed copies and cycle counters
  logic sh_q, lat_q, row_q, frm_q, fell_q; // Last sampled levels
  logic [3:0] nib_q; // Last sampled nibble
  logic [15:0] cnt, since_lat, since_row; // Pulse and distance counters
  // Sample on the system clock; the panel sees only what the block drives
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      {sh_q, lat_q, row_q, frm_q, fell_q, nib_q} <= '0;
      {cnt, since_lat, since_row, o_line_pulses, o_bad, o_lat_frm, o_row_frm} <= '0;
    end else begin
      sh_q <= i_shift;
      nib_q <= i_nibble;
      lat_q <= i_latch;
      row_q <= i_row;
      frm_q <= i_frame;
      fell_q <= sh_q & ~i_shift;
      // Nibble must not move at or just after the sampling fall
      if (i_nibble !== nib_q && ((sh_q & ~i_shift) || fell_q)) o_bad <= o_bad + 1;
      if (sh_q & ~i_shift) cnt <= cnt + 1;
      // Latch rise closes a line: keep its pulse count
      if (i_latch & ~lat_q) begin
        o_line_pulses <= cnt;
        cnt <= '0;
      end
      since_lat <= (lat_q & ~i_latch) ? 16'h0000 : since_lat + 1;
      since_row <= (row_q & ~i_row) ? 16'h0000 : since_row + 1;
      // Frame fall: record distances from the latch and row clock falls
      if (frm_q & ~i_frame) begin
        o_lat_frm <= since_lat + 1;
        o_row_frm <= since_row + 1;
      end
    end
  end
endmodule : lptd_panel_model

// ### verification/test_lcd_panel_timing_and_display_enable.sv
// Self-checking bench: APB register traffic, panel strobe timing, drive enable.
// Assumes lptd_top with zero-wait APB and the panel model beside it.
`timescale 1ns/1ps
`include "lptd_defines.svh"
module test_lcd_panel_timing_and_display_enable;
  // ==========================================
  // Stimulus and observation signals
  logic i_clk = 0, i_rstn = 0, psel = 0, pen = 0, pwr = 0;
  logic [1:0] strap = 2'h1;
  logic [11:0] addr = '0;
  logic [31:0] wd = '0, prdata, rd;
  logic pready, pslverr, shift, latch, frame, row, segc, de, err;
  logic [3:0] nib;
  logic [15:0] lp, bad, lf, rf;
  int n_errors = 0, checked = 0, n, p;
  int exp_per [4] = '{8, 8, 16, 16}; // Strap 00 clamps to 8: 15 MHz ceiling at 100 MHz
  // Clock above the 60 MHz supply limit; the block is cycle-based
  initial forever #5 i_clk = ~i_clk;
  lptd_top lptd_top_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_shift_rate_strap(strap),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd),
    .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_pixel_shift_clock(shift), .o_panel_pixel_nibble(nib), .o_line_latch_pulse(latch),
    .o_frame_start_pulse(frame), .o_row_scan_clock(row), .o_segment_chain_clock(segc),
    .o_panel_drive_enable(de));
  lptd_panel_model lptd_panel_model_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_shift(shift),
    .i_nibble(nib), .i_latch(latch), .i_frame(frame), .i_row(row), .o_line_pulses(lp),
    .o_bad(bad), .o_lat_frm(lf), .o_row_frm(rf));
  // Segment chain rises per line, captured at each latch rise
  logic segc_q = 0, latch_q = 0;
  int segc_n = 0, segc_line = 0;
  always @(posedge i_clk) begin
    segc_q <= segc;
    latch_q <= latch;
    if (latch && !latch_q) begin
      segc_line <= segc_n;
      segc_n <= 0;
    end else if (segc && !segc_q) begin
      segc_n <= segc_n + 1;
    end
  end
  // ==========================================
  // Shared tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    // Idle gap keeps the strobe-only spacing for any pair of cycles
    repeat (9) @(posedge i_clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge i_clk);
    pen <= 1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  // Edges until drive enable reaches lvl, capped at lim+1
  task wait_de(input logic lvl, input int lim);
    n = 0;
    while (de !== lvl && n <= lim) begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask : wait_de
  // Shortest rise-to-rise spacing of the shift clock over 200 cycles
  task per_meas();
    int c;
    logic pv;
    p = 999;
    c = -1;
    pv = 1;
    repeat (200) begin
      @(posedge i_clk);
      #1;
      if (shift && !pv) begin
        if (c >= 0 && c + 1 < p) p = c + 1;
        c = 0;
      end else if (c >= 0) c++;
      pv = shift;
    end
  endtask : per_meas
  // Width in cycles of the next latch (sel 0) or row clock (sel 1) pulse
  task width(input int sel);
    n = 0;
    while ((sel ? row : latch) !== 1'b1) @(posedge i_clk);
    while ((sel ? row : latch) === 1'b1) begin
      @(posedge i_clk);
      n++;
    end
  endtask : width
  task test_done();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // ==========================================
  // Watchdog
  initial begin
    #800000;
    n_errors++;
    test_done();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_rstn <= 1;
    apb(0, `LPTD_OFS_MEMCFG, 0); chk("memcfg", 32'h10, rd);
    apb(0, `LPTD_OFS_GEOM, 0); chk("geom", 32'h0802, rd);
    apb(0, 12'h100, 0); chk("unmapped err", 1, err);
    chk("de at reset", 0, de);
    // Strap table: divider taken on each memcfg write
    for (int s = 0; s < 4; s++) begin
      strap <= s[1:0];
      repeat (6) @(posedge i_clk);
      apb(1, `LPTD_OFS_MEMCFG, 32'h10);
      per_meas(); chk("shift period", exp_per[s], p);
      width(0); chk("latch width", exp_per[s], n);
      width(1); chk("row width", exp_per[s], n);
      width(0);
      chk("pulses per line", 32, lp);
      chk("line multiple", 0, lp % 16);
      chk("segments per line", 2, segc_line);
    end
    strap <= 2'h1;
    repeat (6) @(posedge i_clk);
    apb(1, `LPTD_OFS_MEMCFG, 32'h10);
    repeat (2) @(negedge frame);
    chk("latch to frame", 1, lf >= 16);
    chk("row to frame", 1, rf >= 23);
    chk("nibble stable", 0, bad);
    // Direct mode on and off
    apb(1, `LPTD_OFS_DISPEN, 1); wait_de(1, 2); chk("on delay", 1, n <= 2);
    apb(1, `LPTD_OFS_DISPEN, 0); wait_de(0, 2); chk("off delay", 1, n <= 2);
    apb(1, `LPTD_OFS_CMD, 32'h59); wait_de(1, 20); chk("cmd in direct", 0, de);
    // Indirect mode commands
    apb(1, `LPTD_OFS_MODE, 1);
    apb(1, `LPTD_OFS_DISPEN, 1); wait_de(1, 2); chk("ind on", 1, n <= 2);
    apb(1, `LPTD_OFS_CMD, `LPTD_CMD_DISP_OFF); wait_de(0, 2); chk("cmd off", 1, n <= 2);
    apb(1, `LPTD_OFS_CMD, `LPTD_CMD_DISP_ON); wait_de(1, 2); chk("cmd on", 1, n <= 2);
    apb(0, `LPTD_OFS_CMD, 0); chk("cmd read", 0, rd);
    // Power save in indirect mode: two frames at most
    apb(1, `LPTD_OFS_PWRSAVE, 1); wait_de(0, 5336); chk("save delay", 1, n <= 5328);
    apb(1, `LPTD_OFS_DISPEN, 1); wait_de(1, 30); chk("held low", 0, de);
    apb(1, `LPTD_OFS_MEMCFG, 32'h10); wait_de(1, 30); chk("memcfg disables", 0, de);
    apb(0, `LPTD_OFS_PWRSAVE, 0); chk("save exited", 0, rd[0]);
    apb(0, `LPTD_OFS_DISPEN, 0); chk("dispen cleared", 0, rd[0]);
    apb(1, `LPTD_OFS_DISPEN, 1); wait_de(1, 2); chk("on after exit", 1, n <= 2);
    // Direct power save drops drive enable at once
    apb(1, `LPTD_OFS_MODE, 0);
    apb(1, `LPTD_OFS_PWRSAVE, 1); wait_de(0, 2); chk("direct save", 1, n <= 2);
    test_done();
  end
endmodule : test_lcd_panel_timing_and_display_enable
